/* File: verilog/mchk_regs.vh */
// constants for the machine check interruption logic
// What this block does
// - corrected single-bit storage sets bits 17 and 2
// - corrected storage address goes to 248-251
// - region code: bit, intermittent, cs address, threshold
// - validity bits 24 and 25 mark stored fields
// - timer damage needs mask 13 and external mask
// - clock invalid raises timing damage, bit 4
// - later clock reads report invalid condition code
// - faulty timer feature read interrupts but sets no damage bit
// - uncorrectable instruction error sets bit 1
// - double-bit address to 248-251 or 252-253
// - uncorrected flag; control storage in region byte
// - key failure sets bit 18, block address
// - backed-up bit 14 only if state intact
// - extended logout on first and eighth retry
// - system damage bit 0 for unclassified errors
// - full mode interrupts all but intermittent single-bit fixes
// - check-stop control bit kept in control register 14 but never read by the stop logic
// - check-stop halts at once without logout
// - nested exigent check becomes check-stop
// - reset: reports off, quiet and threshold modes
// - system reset clears status word mask 13
// - reset: check-stop, external, logouts on, cr15=512
`ifndef MCHK_REGS_VH
`define MCHK_REGS_VH
// register port offsets
`define A_CR14      4'h0
`define A_CR15      4'h1
`define A_MASK      4'h2
`define A_CODE_HI   4'h3
`define A_CODE_LO   4'h4
`define A_FADDR     4'h5
`define A_CSADDR    4'h6
`define A_REGION    4'h7
`define A_STATUS    4'h8
`define A_DONE      4'h9
// code bit numbers, bit 0 is the most significant of 64
`define B_SD        0
`define B_PD        1
`define B_SR        2
`define B_TD        3
`define B_CD        4
`define B_BACKED    14
`define B_SE        16
`define B_SC        17
`define B_KE        18
`define B_V_FADDR   24
`define B_V_REGION  25
// control register 14 fields
`define CR14_CHECKSTOP  0
`define CR14_RECOVERY   1
`define CR14_EXTDAMAGE  2
`define CR14_CPU_XLOG   3
`define CR14_IO_XLOG    4
`define CR14_PS_FULL    5
`define CR14_CS_MODE0   6
`define CR14_CS_MODE1   7
`define CR14_RESET      8'h5D
`define CR15_RESET      32'h00000200
// control storage modes
`define CS_QUIET        2'h0
`define CS_THRESH       2'h1
`define CS_FULL         2'h2
`define RETRY_FIRST     4'h1
`define RETRY_EIGHTH    4'h8
`endif

/* File: verilog/retry_counter.v */
// counts unsuccessful retries and marks extended logout attempts
`timescale 1ns/10ps
`include "mchk_regs.vh"
module retry_counter (
   // clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // retry events
   input  wire       clear,
   input  wire       fail,
   // result
   output reg        logout
);
   reg [3:0] cnt_q;
   wire [3:0] cnt_d = (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= 4'h0;
         logout <= 1'b0;
      end else begin
         logout <= 1'b0;
         if (clear) begin
            cnt_q <= 4'h0;
         end else if (fail) begin
            cnt_q  <= cnt_d;
            logout <= (cnt_d == `RETRY_FIRST) ||
                      (cnt_d == `RETRY_EIGHTH);
         end
      end
   end
endmodule

/* File: verilog/mchk_logic.v */
// machine check classification, masking, code and check-stop
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "mchk_regs.vh"
module mchk_logic (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // register port
   input  wire [3:0]  addr,
   input  wire [31:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [31:0] rdata,
   // status word mask and load
   input  wire        sys_reset,
   input  wire        ipl_psw_load,
   input  wire        ipl_psw_mask,
   // error events, one-cycle pulses
   input  wire        ps_single_fix,
   input  wire        cs_single_fix,
   input  wire        intermittent,
   input  wire [7:0]  fixed_bit,
   input  wire        cs_threshold_hit,
   input  wire [31:0] ps_err_addr,
   input  wire [15:0] cs_err_addr,
   input  wire        retry_ok,
   input  wire        timer_damage,
   input  wire        tod_invalid,
   input  wire        timer_read,
   input  wire        timer_feature_err,
   input  wire        ps_double,
   input  wire        cs_double,
   input  wire        key_fail,
   input  wire        cpu_retry_fail,
   input  wire        cpu_unretryable,
   input  wire        state_intact,
   input  wire        irreparable,
   input  wire        unknown_err,
   input  wire        clock_read,
   // results
   output reg         mchk_int,
   output reg         ext_logout,
   output reg         check_stop,
   output reg  [1:0]  clock_cc
);
   reg [7:0]  cr14_q;
   reg [31:0] cr15_q;
   reg        mask13_q;
   reg [63:0] code_q;
   reg [31:0] faddr_q;
   reg [15:0] csaddr_q;
   reg [31:0] region_q;
   reg        exigent_busy_q;
   reg        clock_bad_q;
   wire       logout_pulse;

   wire ext_en   = mask13_q & cr14_q[`CR14_EXTDAMAGE];
   wire rec_en   = cr14_q[`CR14_RECOVERY];
   wire ps_full  = cr14_q[`CR14_PS_FULL];
   wire [1:0] cs_mode = cr14_q[`CR14_CS_MODE1:`CR14_CS_MODE0];

   // repressible and exigent classes, each gated by its own masks
   wire ps_rep = ps_single_fix & rec_en &
                 ps_full & ~intermittent;
   wire cs_rep = cs_single_fix & rec_en &
                 ((cs_mode == `CS_FULL & ~intermittent) |
                  (cs_mode == `CS_THRESH & cs_threshold_hit));
   wire sr_rep = retry_ok & rec_en;
   wire timd   = timer_damage & ext_en;
   wire tfd    = (tod_invalid |
                 (timer_read & timer_feature_err)) & ext_en;
   wire pd_ev  = (ps_double | cs_double | key_fail |
                  cpu_retry_fail | cpu_unretryable) & mask13_q;
   wire sd_ev  = (irreparable | unknown_err) & mask13_q;
   wire exig   = pd_ev | sd_ev;
   wire any_ev = ps_rep | cs_rep | sr_rep | timd | tfd | exig;

   retry_counter u_retry (
      .clk    (clk),
      .rst_n  (rst_n),
      .clear  (retry_ok),
      .fail   (cpu_retry_fail & cr14_q[`CR14_CPU_XLOG]),
      .logout (logout_pulse)
   );

   // code bit n sits at vector position 63-n
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cr14_q         <= `CR14_RESET;
         cr15_q         <= `CR15_RESET;
         mask13_q       <= 1'b0;
         code_q         <= 64'h0;
         faddr_q        <= 32'h0;
         csaddr_q       <= 16'h0;
         region_q       <= 32'h0;
         exigent_busy_q <= 1'b0;
         clock_bad_q    <= 1'b0;
         check_stop     <= 1'b0;
         mchk_int       <= 1'b0;
         ext_logout     <= 1'b0;
         rdata          <= 32'h0;
         clock_cc       <= 2'h0;
      end else if (check_stop) begin
         // hardware halt: only the retry counter moves, nothing is logged
         mchk_int   <= 1'b0;
         ext_logout <= 1'b0;
         rdata      <= 32'h0;
      end else begin
         mchk_int   <= any_ev & ~(exig & exigent_busy_q);
         ext_logout <= logout_pulse;
         rdata      <= 32'h0;
         if (sys_reset) begin
            cr14_q   <= `CR14_RESET;
            cr15_q   <= `CR15_RESET;
            mask13_q <= 1'b0;
         end else if (ipl_psw_load) begin
            mask13_q <= ipl_psw_mask;
         end
         if (tod_invalid) begin
            clock_bad_q <= 1'b1;
         end
         if (clock_read) begin
            clock_cc <= (clock_bad_q | tod_invalid) ? 2'h2 : 2'h0;
         end
         if (exig & exigent_busy_q) begin
            check_stop <= 1'b1;
         end else if (any_ev) begin
            exigent_busy_q <= exig;
            code_q         <= 64'h0;
            region_q       <= 32'h0;
            code_q[63-`B_SD] <= sd_ev;
            code_q[63-`B_PD] <= pd_ev & ~sd_ev;
            code_q[63-`B_SR] <= ps_rep | cs_rep | sr_rep;
            code_q[63-`B_TD] <= timd;
            code_q[63-`B_CD] <= tfd & tod_invalid;
            code_q[63-`B_BACKED] <= pd_ev & cpu_retry_fail &
                                    state_intact;
            code_q[63-`B_SE] <= pd_ev & ps_double;
            code_q[63-`B_SC] <= ps_rep;
            code_q[63-`B_KE] <= pd_ev & key_fail;
            code_q[63-`B_V_FADDR] <= ps_rep |
                                     (pd_ev & (ps_double | key_fail)) |
                                     cs_rep |
                                     (pd_ev & cs_double);
            code_q[63-`B_V_REGION] <= ps_rep | cs_rep |
                                      (pd_ev & cs_double);
            if (ps_rep | (pd_ev & (ps_double | key_fail))) begin
               faddr_q <= ps_err_addr;
            end
            if (cs_rep | (pd_ev & cs_double)) begin
               csaddr_q <= cs_err_addr;
            end
            // region: byte0 bit, byte1 flags, byte2-3 control storage
            region_q <= {fixed_bit,
                         5'h00, cs_threshold_hit & cs_rep,
                         intermittent, cs_rep,
                         cs_rep ? cs_err_addr[7:0] : 8'h00,
                         7'h00, pd_ev & cs_double};
         end
         if (wr) begin
            case (addr)
               `A_CR14: cr14_q <= wdata[7:0];
               `A_CR15: cr15_q <= wdata;
               `A_MASK: mask13_q <= wdata[0];
               // a new exigent event in the same cycle keeps busy set
               `A_DONE: if (!exig) exigent_busy_q <= 1'b0;
               default: ;
            endcase
         end
         if (rd) begin
            case (addr)
               `A_CR14:    rdata <= {24'h0, cr14_q};
               `A_CR15:    rdata <= cr15_q;
               `A_MASK:    rdata <= {31'h0, mask13_q};
               `A_CODE_HI: rdata <= code_q[63:32];
               `A_CODE_LO: rdata <= code_q[31:0];
               `A_FADDR:   rdata <= faddr_q;
               `A_CSADDR:  rdata <= {16'h0, csaddr_q};
               `A_REGION:  rdata <= region_q;
               `A_STATUS:  rdata <= {29'h0, clock_bad_q,
                                     exigent_busy_q, check_stop};
               default:    rdata <= 32'h0;
            endcase
         end
      end
   end
endmodule

/* File: dv/mchk_logic_sva.sv */
// port checker for the machine check logic
`timescale 1ns/10ps
module mchk_logic_sva (
   // clock and reset
   input wire        clk,
   input wire        rst_n,
   // register read
   input wire        rd,
   input wire [31:0] rdata,
   // watched events
   input wire        ps_double,
   input wire        cs_double,
   input wire        key_fail,
   input wire        cpu_unretryable,
   input wire        cpu_retry_fail,
   input wire        irreparable,
   input wire        unknown_err,
   input wire        clock_read,
   // results
   input wire        mchk_int,
   input wire        ext_logout,
   input wire        check_stop,
   input wire [1:0]  clock_cc
);
   wire exig = ps_double | cs_double | key_fail | cpu_unretryable |
               cpu_retry_fail | irreparable | unknown_err;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_CS_STICKY: assert property (check_stop |=> check_stop)
      else $error("check stop dropped");
   AST_CS_QUIET: assert property (check_stop |-> !mchk_int && !ext_logout)
      else $error("activity under check stop");
   AST_CS_RDATA: assert property (rd && check_stop |=> rdata == 32'h0)
      else $error("read answered under check stop");
   AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data without read");
   AST_XLOG_CAUSE: assert property (ext_logout |-> $past(cpu_retry_fail, 2))
      else $error("logout without retry failure");
   AST_CC_HOLD: assert property (!$past(clock_read) |-> $stable(clock_cc))
      else $error("clock cc moved without read");
   AST_CC_VALUE: assert property (clock_cc == 2'h0 || clock_cc == 2'h2)
      else $error("clock cc out of range");
   // the stop lands one cycle after the nested event; the check also accepts two
   AST_CS_CAUSE: assert property ($rose(check_stop) |-> $past(exig) || $past(exig, 2))
      else $error("check stop without exigent event");
endmodule
bind mchk_logic mchk_logic_sva mchk_logic_sva_i (.*);

/* File: dv/mch_model.sv */
// handler software model: closes exigent handling after a think time
`timescale 1ns/10ps
module mch_model (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // handshake
   input wire mchk_int,
   input wire enable,
   output reg done_wr
);
   reg [1:0] wait_q;
   // fixed delay keeps the acknowledge clear of the bench's reads
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q  <= 2'h0;
         done_wr <= 1'b0;
      end else begin
         done_wr <= (wait_q == 2'h1);
         if (mchk_int && enable)
            wait_q <= 2'h3;
         else if (wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
      end
   end
endmodule

/* File: dv/mchk_logic_tb.sv */
// bench for the machine check interruption logic
`timescale 1ns/10ps
`include "mchk_regs.vh"
module mchk_logic_tb;
   reg         clk = 1'b0, rst_n = 1'b0, wr_q = 1'b0, rd_q = 1'b0, ack_en = 1'b1;
   reg  [3:0]  addr_q = 4'h0;
   reg  [31:0] wdata_q = 32'h0, paddr = 32'h0000ABC0, d;
   reg  [20:0] ev = 21'h0;
   wire [31:0] rdata;
   wire        mchk_int, ext_logout, check_stop, done_wr;
   wire [1:0]  clock_cc;
   wire        wr = wr_q | done_wr;
   wire [3:0]  addr = done_wr ? `A_DONE : addr_q;
   integer     n_errors = 0, samples_checked = 0, n_xlog = 0, k;
   mchk_logic mchk_logic_i (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata_q), .wr(wr), .rd(rd_q), .rdata(rdata),
      .sys_reset(ev[18]), .ipl_psw_load(ev[19]), .ipl_psw_mask(ev[20]),
      .ps_single_fix(ev[10]), .cs_single_fix(ev[11]), .intermittent(ev[16]),
      .fixed_bit(paddr[7:0]), .cs_threshold_hit(ev[13]), .ps_err_addr(paddr),
      .cs_err_addr(paddr[15:0]), .retry_ok(ev[12]), .timer_damage(ev[7]),
      .tod_invalid(ev[6]), .timer_read(ev[14]), .timer_feature_err(ev[15]),
      .ps_double(ev[0]), .cs_double(ev[5]), .key_fail(ev[1]),
      .cpu_retry_fail(ev[8]), .cpu_unretryable(ev[2]),
      .state_intact(ev[17]), .irreparable(ev[3]), .unknown_err(ev[4]),
      .clock_read(ev[9]), .mchk_int(mchk_int), .ext_logout(ext_logout),
      .check_stop(check_stop), .clock_cc(clock_cc));
   mch_model mch_model_i (.clk(clk), .rst_n(rst_n), .mchk_int(mchk_int),
      .enable(ack_en), .done_wr(done_wr));
   initial forever #25 clk = ~clk;
   always @(posedge clk) if (ext_logout === 1'b1) n_xlog = n_xlog + 1;
   task chk(input string nm, input [31:0] e, input [31:0] s);
      begin
         samples_checked = samples_checked + 1;
         if (s !== e) begin
            n_errors = n_errors + 1;
            $display("wrong value %0s exp %h got %h", nm, e, s);
         end
      end
   endtask
   task wr_reg(input [3:0] a, input [31:0] v);
      begin
         @(posedge clk) begin wr_q <= 1'b1; addr_q <= a; wdata_q <= v; end
         @(posedge clk) wr_q <= 1'b0;
      end
   endtask
   task rchk(input string nm, input [3:0] a, input [31:0] m, input [31:0] e);
      begin
         @(posedge clk) begin rd_q <= 1'b1; addr_q <= a; end
         @(posedge clk) rd_q <= 1'b0;
         #1 chk(nm, e, rdata & m);
      end
   endtask
   // one event pulse; the handler model closes it five cycles after the interrupt, inside the six-cycle wait
   task pulse(input [20:0] v, input e);
      begin
         @(posedge clk) ev <= v;
         @(posedge clk) ev <= 21'h0;
         #1 chk("mchk_int", {31'h0, e}, {31'h0, mchk_int});
         repeat (6) @(posedge clk);
      end
   endtask
   task t_reset;
      begin
         rchk("cr14", `A_CR14, 32'hFFFFFFFF, 32'h5D);
         rchk("cr15", `A_CR15, 32'hFFFFFFFF, 32'h200);
         rchk("mask", `A_MASK, 32'h1, 32'h0);
         rchk("unmapped", 4'hF, 32'hFFFFFFFF, 32'h0);
      end
   endtask
   task t_mask;
      begin
         pulse(21'h180000, 1'b0);
         rchk("mask", `A_MASK, 32'h1, 32'h1);
         pulse(21'h040000, 1'b0);
         rchk("mask", `A_MASK, 32'h1, 32'h0);
         wr_reg(`A_MASK, 32'h1);
      end
   endtask
   task t_quiet;
      begin
         pulse(21'h000400, 1'b0);
         pulse(21'h000800, 1'b0);
         pulse(21'h001000, 1'b0);
         wr_reg(`A_CR14, 32'h7F);
         pulse(21'h010400, 1'b0);
         pulse(21'h000400, 1'b1);
         rchk("code", `A_CODE_HI, 32'h200040C0, 32'h200040C0);
         rchk("faddr", `A_FADDR, 32'hFFFFFFFF, paddr);
         wr_reg(`A_CR14, 32'h5D);
      end
   endtask
   task t_damage;
      begin
         wr_reg(`A_CR14, 32'h59);
         pulse(21'h000080, 1'b0);
         wr_reg(`A_CR14, 32'h5D);
         pulse(21'h000080, 1'b1);
         pulse(21'h000040, 1'b1);
         rchk("code", `A_CODE_HI, 32'h08000000, 32'h08000000);
         pulse(21'h000200, 1'b0);
         chk("clock_cc", 32'h2, {30'h0, clock_cc});
         pulse(21'h00C000, 1'b1);
      end
   endtask
   task t_exig;
      begin
         for (k = 0; k < 6; k = k + 1)
            pulse(21'h1 << k, 1'b1);
         pulse(21'h000001, 1'b1);
         rchk("code", `A_CODE_HI, 32'h40008080, 32'h40008080);
         rchk("faddr", `A_FADDR, 32'hFFFFFFFF, paddr);
         pulse(21'h000002, 1'b1);
         rchk("code", `A_CODE_HI, 32'h00002000, 32'h00002000);
         pulse(21'h000020, 1'b1);
         rchk("region", `A_REGION, 32'h1, 32'h1);
         rchk("csaddr", `A_CSADDR, 32'hFFFF, paddr & 32'hFFFF);
      end
   endtask
   task t_retry;
      begin
         n_xlog = 0;
         for (k = 0; k < 8; k = k + 1) begin
            pulse(k == 0 ? 21'h020100 : 21'h000100, 1'b1);
            if (k < 2)
               rchk("backed", `A_CODE_HI, 32'h20000, k == 0 ? 32'h20000 : 32'h0);
         end
         chk("logouts", 32'h2, n_xlog);
      end
   endtask
   task t_stop;
      begin
         ack_en <= 1'b0;
         pulse(21'h000001, 1'b1);
         pulse(21'h000002, 1'b0);
         chk("check_stop", 32'h1, {31'h0, check_stop});
         rchk("cr14", `A_CR14, 32'hFFFFFFFF, 32'h0);
         @(posedge clk) rst_n <= 1'b0;
         @(posedge clk) rst_n <= 1'b1;
         #1 chk("check_stop", 32'h0, {31'h0, check_stop});
      end
   endtask
   task summarize;
      begin
         if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_mask;
      t_quiet;
      t_damage;
      t_exig;
      t_retry;
      t_stop;
      summarize;
   end
endmodule
